// ===== logic/swr_regs.vh
// Constants for the single-wire identity command layer (device side).
// Assumes a 20 MHz system clock and a master that keeps slot timing.
`ifndef SWR_REGS_VH
`define SWR_REGS_VH

`define SWR_CLK_MHZ      20
// Bus timing in microseconds, then in clock cycles
`define SWR_T_SAMPLE_US  15
`define SWR_T_HOLD_US    30
`define SWR_T_RESET_US   480
`define SWR_T_PD_WAIT_US 30
`define SWR_T_PD_LOW_US  120
`define SWR_SAMPLE_CYC   (`SWR_T_SAMPLE_US * `SWR_CLK_MHZ)
`define SWR_HOLD_CYC     (`SWR_T_HOLD_US * `SWR_CLK_MHZ)
`define SWR_RESET_CYC    (`SWR_T_RESET_US * `SWR_CLK_MHZ)
`define SWR_PD_WAIT_CYC  (`SWR_T_PD_WAIT_US * `SWR_CLK_MHZ)
`define SWR_PD_LOW_CYC   (`SWR_T_PD_LOW_US * `SWR_CLK_MHZ)

// Command codes
`define SWR_CMD_READ     8'h33
`define SWR_CMD_SKIP     8'hcc
`define SWR_CMD_MATCH    8'h55
`define SWR_CMD_SEARCH   8'hf0

// Check byte generator, reflected form of x^8+x^5+x^4+1
`define SWR_CRC_POLY     8'h8c

// Received word: {is_command, address, byte}
`define SWR_ADDR_W       16
`define SWR_WORD_W       25
`define SWR_FIFO_DEPTH   16

`endif

// ===== logic/swr_rom_layer.v
// Identity command layer of a single-wire bus slave, with its receive FIFO.
// Assumes the line input is asynchronous and the master keeps slot timing.
`timescale 1ns/1ps
`default_nettype none
`include "swr_regs.vh"

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module swr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk,
  input  wire             i_nrst,
  input  wire             i_wr_valid,
  output wire             o_wr_ready,
  input  wire [WIDTH-1:0] i_wr_data,
  output wire             o_rd_valid,
  input  wire             i_rd_ready,
  output wire [WIDTH-1:0] o_rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp;
  reg [AW-1:0]    rp;
  reg [AW:0]      cnt;
  wire            wr_en;
  wire            rd_en;

  assign o_wr_ready = (cnt != DEPTH[AW:0]);
  assign o_rd_valid = (cnt != {(AW+1){1'b0}});
  assign o_rd_data  = mem[rp];
  assign wr_en      = i_wr_valid & o_wr_ready;
  assign rd_en      = o_rd_valid & i_rd_ready;

  always @(posedge i_clk) begin
    if (wr_en) begin
      mem[wp] <= i_wr_data;
    end
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (wr_en) begin
        wp <= wp + 1'b1;
      end
      if (rd_en) begin
        rp <= rp + 1'b1;
      end
      if (wr_en & ~rd_en) begin
        cnt <= cnt + 1'b1;
      end else if (rd_en & ~wr_en) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule // swr_fifo

// ----------------------------------------
// Identity command layer
// ----------------------------------------
module swr_rom_layer #(
  parameter [7:0]  FAMILY    = 8'h2a,           // Arbitrary value
  parameter [47:0] SERIAL    = 48'h0123456789ab, // Arbitrary value
  parameter        RESET_CYC = `SWR_RESET_CYC
) (
  input  wire                   i_clk,
  input  wire                   i_nrst,
  input  wire                   i_line_in,
  output reg                    o_line_out,
  output reg                    o_line_oe,
  input  wire                   i_mem_read,
  input  wire [7:0]             i_tx_byte,
  output reg  [`SWR_ADDR_W-1:0] o_tx_addr,
  output reg                    o_rx_valid,
  input  wire                   i_rx_ready,
  output reg  [`SWR_WORD_W-1:0] o_rx_word,
  output reg                    o_overflow,
  output reg                    o_mem_active,
  output reg                    o_idle
);
  localparam [2:0] ST_CMD   = 3'h0;
  localparam [2:0] ST_READ  = 3'h1;
  localparam [2:0] ST_MATCH = 3'h2;
  localparam [2:0] ST_SRCH  = 3'h3;
  localparam [2:0] ST_MCMD  = 3'h4;
  localparam [2:0] ST_MDATA = 3'h5;
  localparam [2:0] ST_IDLE  = 3'h6;

  localparam [1:0] PR_NONE = 2'h0;
  localparam [1:0] PR_RISE = 2'h1;
  localparam [1:0] PR_WAIT = 2'h2;
  localparam [1:0] PR_LOW  = 2'h3;

  localparam integer SMP_END = `SWR_SAMPLE_CYC - 1;
  localparam integer HLD_END = `SWR_HOLD_CYC - 1;
  localparam integer RST_END = RESET_CYC - 1;
  localparam integer PDW_END = `SWR_PD_WAIT_CYC - 1;
  localparam integer PDL_END = `SWR_PD_LOW_CYC - 1;

  function [7:0] swr_crc;
    input [55:0] data;
    integer k;
    reg [7:0] c;
    begin
      c = 8'h00;
      for (k = 0; k < 56; k = k + 1) begin
        if (c[0] ^ data[k]) begin
          c = (c >> 1) ^ `SWR_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      swr_crc = c;
    end
  endfunction

  // Identity: check byte on top, family at the bottom
  localparam [63:0] ROM = {swr_crc({SERIAL, FAMILY}), SERIAL, FAMILY};

  reg        s1;
  reg        s2;
  reg        prev;
  reg [13:0] lcnt;
  reg [1:0]  pst;
  reg [13:0] pcnt;
  reg        slot;
  reg [13:0] scnt;
  reg [2:0]  st;
  reg [1:0]  ph;
  reg [5:0]  idx;
  reg [7:0]  sh;
  reg [2:0]  bcnt;
  reg [7:0]  txsh;
  reg        push;
  reg [`SWR_WORD_W-1:0] push_word;

  wire       fall;
  wire       rom_bit;
  reg        rd_slot;
  reg        rd_bit;
  wire       bit_in;
  wire [7:0] next_sh;
  wire       fifo_ready;
  wire       fifo_valid;
  wire [`SWR_WORD_W-1:0] fifo_data;
  wire       fifo_pop;

  assign fall    = prev & ~s2;
  assign rom_bit = ROM[idx];
  assign bit_in  = rd_slot ? rd_bit : s2;
  assign next_sh = {bit_in, sh[7:1]};

  // Which slots the device answers, and with what bit
  always @* begin
    rd_slot = 1'b0;
    rd_bit  = 1'b1;
    case (st)
      ST_READ: begin
        rd_slot = 1'b1;
        rd_bit  = rom_bit;
      end
      ST_SRCH: begin
        rd_slot = (ph != 2'h2);
        rd_bit  = (ph == 2'h0) ? rom_bit : ~rom_bit;
      end
      ST_MDATA: begin
        rd_slot = i_mem_read;
        rd_bit  = (bcnt == 3'h0) ? i_tx_byte[0] : txsh[0];
      end
      default: begin
        rd_slot = 1'b0;
        rd_bit  = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Line sampling, reset, presence and slots
  // ----------------------------------------
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1           <= 1'b1;
      s2           <= 1'b1;
      prev         <= 1'b1;
      lcnt         <= 14'h0000;
      pst          <= PR_NONE;
      pcnt         <= 14'h0000;
      slot         <= 1'b0;
      scnt         <= 14'h0000;
      st           <= ST_CMD;
      ph           <= 2'h0;
      idx          <= 6'h00;
      sh           <= 8'h00;
      bcnt         <= 3'h0;
      txsh         <= 8'h00;
      push         <= 1'b0;
      push_word    <= {`SWR_WORD_W{1'b0}};
      o_line_out   <= 1'b0;
      o_line_oe    <= 1'b0;
      o_tx_addr    <= {`SWR_ADDR_W{1'b0}};
      o_overflow   <= 1'b0;
      o_mem_active <= 1'b0;
      o_idle       <= 1'b0;
    end else begin
      s1   <= i_line_in;
      s2   <= s1;
      prev <= s2;
      push <= 1'b0;
      // Full FIFO cannot stall the master, so the byte is lost and flagged
      if (push & ~fifo_ready) begin
        o_overflow <= 1'b1;
      end
      // Own presence drive must not count as a bus reset
      lcnt <= (s2 | (pst != PR_NONE)) ? 14'h0000 :
              ((lcnt == 14'h3fff) ? lcnt : lcnt + 14'h0001);
      o_mem_active <= (st == ST_MCMD) | (st == ST_MDATA);
      o_idle       <= (st == ST_IDLE);

      if (!s2 && lcnt == RST_END[13:0]) begin
        // Long low resynchronises every state, idle included
        pst       <= PR_RISE;
        slot      <= 1'b0;
        o_line_oe <= 1'b0;
        st        <= ST_CMD;
        ph        <= 2'h0;
        idx       <= 6'h00;
        bcnt      <= 3'h0;
        o_tx_addr <= {`SWR_ADDR_W{1'b0}};
      end else if (pst != PR_NONE) begin
        case (pst)
          PR_RISE: begin
            if (s2) begin
              pst  <= PR_WAIT;
              pcnt <= 14'h0000;
            end
          end
          PR_WAIT: begin
            pcnt <= pcnt + 14'h0001;
            if (pcnt == PDW_END[13:0]) begin
              pst       <= PR_LOW;
              pcnt      <= 14'h0000;
              o_line_oe <= 1'b1;
            end
          end
          PR_LOW: begin
            pcnt <= pcnt + 14'h0001;
            if (pcnt == PDL_END[13:0]) begin
              pst       <= PR_NONE;
              o_line_oe <= 1'b0;
            end
          end
          default: begin
            pst <= PR_NONE;
          end
        endcase
      end else if (!slot) begin
        if (fall) begin
          slot      <= 1'b1;
          scnt      <= 14'h0000;
          o_line_oe <= rd_slot & ~rd_bit;
        end
      end else begin
        scnt <= scnt + 14'h0001;
        if (scnt == HLD_END[13:0]) begin
          slot      <= 1'b0;
          o_line_oe <= 1'b0;
        end
        if (scnt == SMP_END[13:0]) begin
          case (st)
            ST_CMD: begin
              sh   <= next_sh;
              bcnt <= bcnt + 3'h1;
              if (bcnt == 3'h7) begin
                idx <= 6'h00;
                ph  <= 2'h0;
                case (next_sh)
                  `SWR_CMD_READ:   st <= ST_READ;
                  `SWR_CMD_MATCH:  st <= ST_MATCH;
                  `SWR_CMD_SEARCH: st <= ST_SRCH;
                  `SWR_CMD_SKIP:   st <= ST_MCMD;
                  default:         st <= ST_IDLE;
                endcase
              end
            end
            ST_READ: begin
              idx <= idx + 6'h01;
              if (idx == 6'h3f) begin
                st <= ST_MCMD;
              end
            end
            ST_MATCH: begin
              idx <= idx + 6'h01;
              if (bit_in != rom_bit) begin
                st <= ST_IDLE;
              end else if (idx == 6'h3f) begin
                st <= ST_MCMD;
              end
            end
            ST_SRCH: begin
              if (ph != 2'h2) begin
                ph <= ph + 2'h1;
              end else if (bit_in != rom_bit) begin
                st <= ST_IDLE;
              end else if (idx == 6'h3f) begin
                st <= ST_MCMD;
              end else begin
                idx <= idx + 6'h01;
                ph  <= 2'h0;
              end
            end
            ST_MCMD: begin
              sh   <= next_sh;
              bcnt <= bcnt + 3'h1;
              if (bcnt == 3'h7) begin
                push      <= 1'b1;
                push_word <= {1'b1, o_tx_addr, next_sh};
                st        <= ST_MDATA;
              end
            end
            ST_MDATA: begin
              bcnt <= bcnt + 3'h1;
              if (rd_slot) begin
                txsh <= (bcnt == 3'h0) ? {1'b0, i_tx_byte[7:1]} : {1'b0, txsh[7:1]};
              end else begin
                sh <= next_sh;
              end
              if (bcnt == 3'h7) begin
                o_tx_addr <= o_tx_addr + 1'b1;
                if (!rd_slot) begin
                  push      <= 1'b1;
                  push_word <= {1'b0, o_tx_addr, next_sh};
                end
              end
            end
            default: begin
              st <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Received bytes toward the memory layer
  // ----------------------------------------
  swr_fifo #(
    .WIDTH (`SWR_WORD_W),
    .DEPTH (`SWR_FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_nrst     (i_nrst),
    .i_wr_valid (push),
    .o_wr_ready (fifo_ready),
    .i_wr_data  (push_word),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (fifo_pop),
    .o_rd_data  (fifo_data)
  );

  // Output stage keeps the user side registered
  assign fifo_pop = fifo_valid & (~o_rx_valid | i_rx_ready);

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_valid <= 1'b0;
      o_rx_word  <= {`SWR_WORD_W{1'b0}};
    end else begin
      if (fifo_pop) begin
        o_rx_valid <= 1'b1;
        o_rx_word  <= fifo_data;
      end else if (i_rx_ready) begin
        o_rx_valid <= 1'b0;
      end
    end
  end
endmodule // swr_rom_layer

`default_nettype wire

// ===== test/swr_rom_layer_monitor.sv
// Port checker for the identity command layer.
// Assumes it is bound to every swr_rom_layer instance.
`timescale 1ns/1ps
`default_nettype none
module swr_rom_layer_monitor (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_line_in,
  input wire logic        i_rx_ready,
  input wire logic        o_line_out,
  input wire logic        o_line_oe,
  input wire logic [15:0] o_tx_addr,
  input wire logic        o_rx_valid,
  input wire logic [24:0] o_rx_word,
  input wire logic        o_overflow,
  input wire logic        o_mem_active,
  input wire logic        o_idle
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [11:0] run;
  // Drive length, judged when the drive ends: a slot or a presence pulse
  always @(posedge i_clk or negedge i_nrst)
    if (!i_nrst) run <= 12'h0;
    else run <= o_line_oe ? run + 12'h1 : 12'h0;
  chk_line_open: assert property (o_line_out == 1'b0)
    else $error("line data bit not low");
  chk_drive_len: assert property ($fell(o_line_oe) |-> run == 12'h258 || run == 12'h960)
    else $error("drive length wrong");
  chk_idle_quiet: assert property (o_idle |-> !o_line_oe)
    else $error("idle device drives line");
  chk_idle_unsel: assert property (o_idle |-> !o_mem_active)
    else $error("idle device still selected");
  chk_addr_step: assert property ($changed(o_tx_addr) |->
      o_tx_addr == $past(o_tx_addr) + 16'h1 || o_tx_addr == 16'h0)
    else $error("address jump");
  chk_rx_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_word))
    else $error("received word dropped");
  chk_ovf_sticky: assert property (o_overflow |=> o_overflow)
    else $error("overflow flag cleared");
  chk_mem_exit: assert property ($fell(o_mem_active) |->
      $past(i_line_in, 100) == 1'b0 && $past(i_line_in, 300) == 1'b0)
    else $error("left memory layer without bus reset");
  chk_idle_exit: assert property ($fell(o_idle) |->
      $past(i_line_in, 100) == 1'b0 && $past(i_line_in, 300) == 1'b0)
    else $error("left idle without bus reset");
endmodule // swr_rom_layer_monitor
bind swr_rom_layer swr_rom_layer_monitor u_mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_line_in(i_line_in), .i_rx_ready(i_rx_ready), .o_line_out(o_line_out),
  .o_line_oe(o_line_oe), .o_tx_addr(o_tx_addr), .o_rx_valid(o_rx_valid),
  .o_rx_word(o_rx_word), .o_overflow(o_overflow), .o_mem_active(o_mem_active),
  .o_idle(o_idle));
`default_nettype wire

// ===== test/swr_bus_master.sv
// Bus master model: reset pulses and read and write slots on the line.
// Assumes a pull-up on the line and the 20 MHz bench clock.
`timescale 1ns/1ps
`default_nettype none
module swr_bus_master (
  input  wire logic i_clk,
  input  wire logic i_line,
  output var logic  o_pull
);
  initial o_pull = 1'b0;
  // A written zero holds past the sample point but ends before the slot does
  task automatic slot(input logic b, output logic r);
    @(posedge i_clk) o_pull <= 1'b1;
    repeat (5) @(posedge i_clk);
    if (b) o_pull <= 1'b0;
    repeat (140) @(posedge i_clk);
    @(negedge i_clk) r = i_line;
    repeat (400) @(posedge i_clk);
    o_pull <= 1'b0;
    repeat (60) @(posedge i_clk);
  endtask
  task automatic wr_byte(input logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) slot(d[i], r);
  endtask
  task automatic rd_byte(output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      slot(1'b1, r);
      d = {r, d[7:1]};
    end
  endtask
  task automatic bus_reset(input int low, output logic pres);
    @(posedge i_clk) o_pull <= 1'b1;
    repeat (low) @(posedge i_clk);
    o_pull <= 1'b0;
    repeat (1500) @(posedge i_clk);
    @(negedge i_clk) pres = !i_line;
    repeat (1520) @(posedge i_clk);
  endtask
endmodule // swr_bus_master
`default_nettype wire

// ===== test/swr_rom_layer_tb.sv
// Self-checking bench for the identity command layer.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module swr_rom_layer_tb;
  localparam logic [7:0]  FAM = 8'h2a;            // Arbitrary value
  localparam logic [47:0] SER = 48'h0123456789ab; // Arbitrary value
  localparam int          RST = 700;
  logic             i_clk, i_nrst, i_mem_read, i_rx_ready;
  logic [7:0]       i_tx_byte, b;
  logic             pull, pres, r;
  logic [63:0]      id;
  logic [1:0]       lrn;
  int               n_mismatch = 0;
  int               samples_checked = 0;
  wire logic        out, oe, valid, mem, idle, ovf;
  wire logic [15:0] addr;
  wire logic [24:0] word;
  wire logic        line = !(pull || (oe && !out));
  swr_bus_master m (.i_clk(i_clk), .i_line(line), .o_pull(pull));
  swr_rom_layer #(.FAMILY(FAM), .SERIAL(SER), .RESET_CYC(RST)) DUT (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_line_in(line), .o_line_out(out), .o_line_oe(oe),
    .i_mem_read(i_mem_read), .i_tx_byte(i_tx_byte), .o_tx_addr(addr), .o_rx_valid(valid),
    .i_rx_ready(i_rx_ready), .o_rx_word(word), .o_overflow(ovf), .o_mem_active(mem),
    .o_idle(idle));
  function automatic logic [7:0] crc8(input logic [55:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ v[i]) ? (c >> 1) ^ 8'h8c : c >> 1;
    return c;
  endfunction
  task automatic start(input logic [7:0] cmd);
    m.bus_reset(RST + 20, pres);
    `CHK("presence", 1'b1, pres)
    m.wr_byte(cmd);
  endtask
  task automatic t_unknown;
    start(8'h99);
    `CHK("idle", 2'b10, {idle, mem})
    m.slot(1'b1, r);
    `CHK("quiet", 1'b1, r)
  endtask
  // Bits learned by the search keep the device, a wrong third bit drops it
  task automatic t_match_miss;
    start(8'h55);
    m.slot(lrn[0], r);
    m.slot(lrn[1], r);
    `CHK("match kept", 1'b0, idle)
    m.slot(!FAM[2], r);
    `CHK("match idle", 2'b10, {idle, mem})
  endtask
  task automatic t_read_id;
    start(8'h33);
    for (int i = 0; i < 8; i++) begin
      m.rd_byte(b);
      id[i*8 +: 8] = b;
    end
    `CHK("identity", {crc8({SER, FAM}), SER, FAM}, id)
    `CHK("selected", 1'b1, mem)
  endtask
  task automatic t_skip;
    logic [15:0] a0;
    start(8'hcc);
    `CHK("skip", 1'b1, mem)
    i_rx_ready <= 1'b0;
    m.wr_byte(8'h3c);
    `CHK("cmd word", 10'h33c, {valid, word[24], word[7:0]})
    @(posedge i_clk) i_rx_ready <= 1'b1;
    i_mem_read <= 1'b1;
    i_tx_byte <= 8'ha5;
    a0 = addr;
    m.rd_byte(b);
    `CHK("mem byte", 8'ha5, b)
    `CHK("address", a0 + 16'h1, addr)
    i_mem_read <= 1'b0;
    `CHK("no overflow", 1'b0, ovf)
  endtask
  task automatic t_search;
    logic [3:0] got;
    start(8'hf0);
    for (int i = 0; i < 2; i++) begin
      m.slot(1'b1, r);
      got = {r, got[3:1]};
      m.slot(1'b1, r);
      got = {r, got[3:1]};
      m.slot(1'b0, r);
    end
    `CHK("search reads", {~FAM[1], FAM[1], ~FAM[0], FAM[0]}, got)
    // Select zero keeps bit 0, then drops the device at bit 1
    `CHK("search idle", FAM[1], idle)
    `CHK("no conflict", 2'b11, {got[3] ^ got[2], got[1] ^ got[0]})
    lrn = {got[2], got[0]};
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    end_sim;
  end
  initial begin
    i_nrst = 1'b0;
    i_mem_read = 1'b0;
    i_tx_byte = 8'h00;
    i_rx_ready = 1'b1;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (5) @(posedge i_clk);
    t_unknown;
    t_search;
    t_match_miss;
    t_read_id;
    t_skip;
    end_sim;
  end
endmodule // swr_rom_layer_tb
`default_nettype wire
